//--- src/dnra_core.sv
// Purpose: slave-side register access for a drive network option board
// Assumes: requests come from network logic on clk; link_alive and ser_in are pins
// Notes: fast words live in a local shared memory; slow words travel a serial frame
`timescale 1ns/1ps
module dnra_core
	import dnra_pkg::*;
#(
	parameter int unsigned STORE_CYC = STORE_COMMIT_CYC,
	parameter int unsigned APPLY_CYC = APPLY_COMMIT_CYC,
	parameter int unsigned GR_CYC = GR_FAST_CYC,
	parameter int unsigned GRW_CYC = GRW_FAST_CYC,
	parameter int unsigned GSER_CYC = GLB_SER_CYC,
	parameter int unsigned SER_DIV = SER_DIV_DEF,
	parameter logic [15:0] MODEL_NUMBER = 16'h0A5A // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire dnra_req_t req,
	output dnra_resp_t resp,
	output logic req_ready,
	input wire logic global_read_en,
	input wire logic cable_loss_det_en,
	input wire logic link_alive,
	input wire logic commit_store,
	input wire logic commit_apply,
	input wire logic freq_scale_sel,
	input wire logic [4:0] drv_addr,
	output logic [15:0] drv_rdata,
	output logic ser_frame,
	output logic ser_dir,
	output logic ser_out,
	output logic ser_tick,
	input wire logic ser_in,
	output logic [15:0] op_command,
	output logic [15:0] freq_cmd,
	output logic external_fault_code,
	output logic cable_loss,
	output logic run_inhibit,
	output logic keypad_write_protect,
	output logic commit_busy,
	output logic commit_done
);
	if (SER_DIV < 2 || SER_DIV > 16 || STORE_CYC < 1 || APPLY_CYC < 1) begin : g_bad_param
		$error("dnra_core: unsupported parameter value");
	end

	typedef struct packed {
		dnra_state_t st;
		logic [31:0] wait_cnt;
		logic [31:0] commit_cnt;
		logic [5:0] bitcnt;
		logic [3:0] div;
		logic [31:0] shreg;
		logic [15:0] rdbuf;
		logic err;
		logic quiet;
		logic [15:0] gw_node;
		logic [15:0] gf_mult;
		logic pend_any;
		logic pend_nonrun;
		logic armed;
		logic [1:0] link_sync;
		logic [1:0] ser_sync;
		dnra_resp_t resp;
		logic ready;
		logic ser_frame;
		logic ser_dir;
		logic ser_out;
		logic ser_tick;
		logic [15:0] opcmd;
		logic [15:0] freq;
		logic [15:0] freq_out;
		logic ext_fault;
		logic cable_loss;
		logic commit_busy;
		logic commit_done;
	} dnra_core_state_t;

	dnra_core_state_t s;
	dnra_core_state_t next_s;
	logic [15:0] fast_mem [32];
	logic mem_we;
	logic [4:0] mem_idx;
	logic [15:0] mem_wdata;

	logic in_fast;
	logic in_ser;
	logic in_local;
	logic single_only;
	logic tick;
	logic gw_en;
	logic [31:0] prod;
	// a parameter write landing with a commit must survive it
	logic set_any;
	logic set_nonrun;

	always_comb begin
		in_fast = (req.addr >= FAST_LO_A && req.addr <= FAST_HI_A) ||
			(req.addr >= FAST_LO_B && req.addr <= FAST_HI_B);
		in_ser = (req.addr >= SER_LO_A && req.addr <= SER_HI_A) ||
			(req.addr >= SER_LO_B && req.addr <= SER_HI_B);
		single_only = req.addr == ADDR_GLOBAL_WRITE_NODE_NUMBER ||
			req.addr == ADDR_GLOBAL_FREQUENCY_MULTIPLIER || req.addr == ADDR_DRIVE_MODEL_NUMBER;
		in_local = single_only;
		tick = s.div == 4'(SER_DIV - 1);
		gw_en = s.gw_node != WORD_RST;
		prod = s.freq * s.gf_mult;
	end

	always_comb begin
		next_s = s;
		set_any = 1'b0;
		set_nonrun = 1'b0;
		mem_we = 1'b0;
		mem_idx = {req.addr[15], req.addr[3:0]};
		mem_wdata = req.wdata;
		next_s.resp.valid = 1'b0;
		next_s.commit_done = 1'b0;
		next_s.link_sync = {s.link_sync[0], link_alive};
		next_s.ser_sync = {s.ser_sync[0], ser_in};
		next_s.div = tick ? 4'h0 : s.div + 4'h1;
		next_s.ser_tick = tick;
		case (s.st)
			DNRA_IDLE: begin
				if (req.valid) begin
					next_s.err = 1'b0;
					next_s.quiet = req.global_op;
					next_s.rdbuf = WORD_RST;
					next_s.wait_cnt = '0;
					next_s.st = DNRA_WAIT;
					// only a directed command from the master arms cable loss detection here
					if (!req.global_op) begin
						next_s.armed = 1'b1;
					end
					if (req.global_op) begin
						// global traffic carries only the two command words
						if (req.write && gw_en && (req.addr == ADDR_OPERATION_COMMAND ||
							req.addr == ADDR_FREQUENCY_REFERENCE)) begin
							mem_we = 1'b1;
							if (req.addr == ADDR_OPERATION_COMMAND) begin
								next_s.opcmd = req.wdata;
							end else begin
								next_s.freq = req.wdata;
							end
							next_s.wait_cnt = GRW_CYC;
						end
					end else if (single_only && req.len != SINGLE_WORD_LEN) begin
						next_s.err = 1'b1;
					end else if (req.write && req.addr == ADDR_DRIVE_MODEL_NUMBER) begin
						next_s.err = 1'b1;
					end else if (req.write && gw_en && (req.addr == ADDR_OPERATION_COMMAND ||
						req.addr == ADDR_FREQUENCY_REFERENCE)) begin
						// directed command words would fight the global copy
						next_s.err = 1'b1;
					end else if (in_fast) begin
						if (req.write) begin
							mem_we = 1'b1;
							if (req.addr == ADDR_OPERATION_COMMAND) begin
								next_s.opcmd = req.wdata;
							end
							if (req.addr == ADDR_FREQUENCY_REFERENCE) begin
								next_s.freq = req.wdata;
							end
						end else begin
							next_s.rdbuf = fast_mem[mem_idx];
						end
						if (gw_en) begin
							next_s.wait_cnt = GRW_CYC;
						end else if (global_read_en) begin
							next_s.wait_cnt = GR_CYC;
						end
					end else if (in_local) begin
						if (req.write) begin
							if (req.addr == ADDR_GLOBAL_WRITE_NODE_NUMBER) begin
								next_s.gw_node = req.wdata;
							end else begin
								next_s.gf_mult = req.wdata;
							end
						end else begin
							case (req.addr)
								ADDR_GLOBAL_WRITE_NODE_NUMBER: next_s.rdbuf = s.gw_node;
								ADDR_GLOBAL_FREQUENCY_MULTIPLIER: next_s.rdbuf = s.gf_mult;
								default: next_s.rdbuf = MODEL_NUMBER;
							endcase
						end
					end else if (in_ser) begin
						next_s.st = DNRA_SER;
						next_s.shreg = {req.addr, req.wdata};
						next_s.ser_dir = req.write;
						next_s.bitcnt = '0;
						if (req.write) begin
							next_s.pend_any = 1'b1;
							set_any = 1'b1;
							if (!dnra_is_run_op(req.addr)) begin
								next_s.pend_nonrun = 1'b1;
								set_nonrun = 1'b1;
							end
						end
					end else begin
						next_s.err = 1'b1;
					end
				end
			end
			DNRA_SER: begin
				if (tick) begin
					next_s.ser_frame = 1'b1;
					next_s.bitcnt = s.bitcnt + 6'h01;
					if (s.bitcnt < SER_OUT_BITS) begin
						next_s.ser_out = s.shreg[31];
						next_s.shreg = {s.shreg[30:0], 1'b0};
					end else begin
						// read back rides on every frame; writes simply drop it
						next_s.rdbuf = {s.rdbuf[14:0], s.ser_sync[1]};
					end
					if (s.bitcnt == SER_LAST_BIT) begin
						next_s.ser_frame = 1'b0;
						next_s.ser_out = 1'b0;
						next_s.st = DNRA_WAIT;
						next_s.wait_cnt = (gw_en || global_read_en) ? GSER_CYC : 32'h0000_0000;
					end
				end
			end
			DNRA_WAIT: begin
				if (s.wait_cnt == 32'h0000_0000) begin
					next_s.st = DNRA_IDLE;
					next_s.resp.valid = !s.quiet;
					next_s.resp.err = s.err;
					next_s.resp.rdata = s.ser_dir ? WORD_RST : s.rdbuf;
					next_s.ser_dir = 1'b0;
				end else begin
					next_s.wait_cnt = s.wait_cnt - 32'h0000_0001;
				end
			end
			default: begin
				next_s.st = DNRA_IDLE;
			end
		endcase
		// commit: flags drop on the command, a fresh write in the same cycle wins
		if (s.commit_busy) begin
			if (s.commit_cnt == 32'h0000_0001) begin
				next_s.commit_busy = 1'b0;
				next_s.commit_done = 1'b1;
			end
			next_s.commit_cnt = s.commit_cnt - 32'h0000_0001;
		end else if (commit_store || commit_apply) begin
			next_s.commit_busy = 1'b1;
			next_s.commit_cnt = commit_store ? STORE_CYC : APPLY_CYC;
			if (!set_any) begin
				next_s.pend_any = 1'b0;
			end
			if (!set_nonrun) begin
				next_s.pend_nonrun = 1'b0;
			end
		end
		next_s.ready = next_s.st == DNRA_IDLE;
		next_s.ext_fault = next_s.opcmd[OPC_RUN_FWD] & next_s.opcmd[OPC_RUN_REV];
		next_s.cable_loss = cable_loss_det_en & s.armed & ~s.link_sync[1];
		next_s.freq_out = freq_scale_sel ? prod[15:0] : s.freq;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= DNRA_IDLE;
			s.gf_mult <= 16'h0001;
		end else begin
			s <= next_s;
		end
	end

	// shared storage: network side writes, drive side reads each cycle
	always_ff @(posedge clk) begin
		if (mem_we) begin
			fast_mem[mem_idx] <= mem_wdata;
		end
		drv_rdata <= fast_mem[drv_addr];
	end

	always_comb begin
		resp = s.resp;
		req_ready = s.ready;
		ser_frame = s.ser_frame;
		ser_dir = s.ser_dir;
		ser_out = s.ser_out;
		ser_tick = s.ser_tick;
		op_command = s.opcmd;
		freq_cmd = s.freq_out;
		external_fault_code = s.ext_fault;
		cable_loss = s.cable_loss;
		run_inhibit = s.pend_nonrun;
		keypad_write_protect = s.pend_any;
		commit_busy = s.commit_busy;
		commit_done = s.commit_done;
	end

	// helper: length of the current commit busy stretch
	logic [31:0] chk_commit_len;
	always_ff @(posedge clk) begin
		if (!rst_n || !s.commit_busy) begin
			chk_commit_len <= 32'h0000_0000;
		end else begin
			chk_commit_len <= chk_commit_len + 32'h0000_0001;
		end
	end

	sequence seq_fast_read;
		s.st == DNRA_IDLE && req.valid && !req.write && !req.global_op && req.addr == ADDR_FREQUENCY_REFERENCE
			&& !global_read_en && !gw_en;
	endsequence
	sequence seq_fast_answer;
		##2 resp.valid && !resp.err && resp.rdata == $past(s.freq, 2);
	endsequence
	sequence seq_ser_start;
		s.st == DNRA_IDLE && req.valid && !req.global_op && in_ser && !single_only;
	endsequence

	a_fast_read_path: assert property (@(posedge clk) disable iff (!rst_n)
		seq_fast_read |-> seq_fast_answer) else $error("fast read not answered in two cycles");
	a_serial_frame_use: assert property (@(posedge clk) disable iff (!rst_n)
		seq_ser_start ##1 1'b1 |-> !resp.valid [*8]) else $error("serial access answered too early");
	a_commit_time: assert property (@(posedge clk) disable iff (!rst_n)
		commit_done |-> $past(chk_commit_len) == STORE_CYC - 1 || $past(chk_commit_len) == APPLY_CYC - 1)
		else $error("commit busy time wrong");
	a_global_delay: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == DNRA_IDLE && req.valid && in_fast && !req.global_op && !single_only && gw_en
		&& !(req.write && (req.addr == ADDR_OPERATION_COMMAND || req.addr == ADDR_FREQUENCY_REFERENCE))
		|-> ##1 s.wait_cnt == GRW_CYC) else $error("global write delay not loaded");
	a_resp_has_cause: assert property (@(posedge clk) disable iff (!rst_n)
		resp.valid |-> $past(s.st) == DNRA_WAIT) else $error("answer without a request");
	a_cable_unarmed: assert property (@(posedge clk) disable iff (!rst_n)
		!s.armed |=> !cable_loss) else $error("cable loss before first directed command");
	a_run_dir_fault: assert property (@(posedge clk) disable iff (!rst_n)
		s.opcmd[OPC_RUN_FWD] && s.opcmd[OPC_RUN_REV] |-> external_fault_code)
		else $error("conflicting run direction without fault");
	a_single_word_only: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == DNRA_IDLE && req.valid && !req.global_op && single_only && req.len != SINGLE_WORD_LEN
		|-> ##[1:3] resp.valid && resp.err) else $error("multi-word access to single-word register");
	a_run_block: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == DNRA_IDLE && req.valid && req.write && !req.global_op && in_ser && !dnra_is_run_op(req.addr)
		|=> run_inhibit && keypad_write_protect) else $error("parameter write did not block run");
	a_runop_free: assert property (@(posedge clk) disable iff (!rst_n)
		s.st == DNRA_IDLE && req.valid && req.write && dnra_is_run_op(req.addr) && !run_inhibit
		&& !commit_store && !commit_apply |=> !run_inhibit) else $error("run-operative write blocked run");
	a_commit_clears: assert property (@(posedge clk) disable iff (!rst_n)
		!s.commit_busy && commit_apply && !(s.st == DNRA_IDLE && req.valid)
		|=> !run_inhibit && !keypad_write_protect) else $error("commit left pending flag set");
endmodule

//--- src/dnra_pkg.sv
// Purpose: shared constants and types for the drive network register access block
// Assumes: 200 MHz clock, 16-bit register words, 16-bit register numbers
// Notes: times are kept in ns; cycle counts derive from them and the clock period
package dnra_pkg;
	// register numbers
	localparam logic [15:0] ADDR_OPERATION_COMMAND = 16'h0001;
	localparam logic [15:0] ADDR_FREQUENCY_REFERENCE = 16'h0002;
	localparam logic [15:0] FAST_LO_A = 16'h0001;
	localparam logic [15:0] FAST_HI_A = 16'h000F;
	localparam logic [15:0] FAST_LO_B = 16'hF000;
	localparam logic [15:0] FAST_HI_B = 16'hF00F;
	localparam logic [15:0] SER_LO_A = 16'h0020;
	localparam logic [15:0] SER_HI_A = 16'h050D;
	localparam logic [15:0] SER_LO_B = 16'hF100;
	localparam logic [15:0] SER_HI_B = 16'hF10F;
	localparam logic [15:0] ADDR_GLOBAL_WRITE_NODE_NUMBER = 16'hF200;
	localparam logic [15:0] ADDR_GLOBAL_FREQUENCY_MULTIPLIER = 16'hF201;
	localparam logic [15:0] ADDR_DRIVE_MODEL_NUMBER = 16'hF202;
	localparam int RUN_OP_COUNT = 41;
	localparam logic [15:0] RUN_OP_TABLE [RUN_OP_COUNT] = '{
		16'h0100, 16'h0101, 16'h0180, 16'h0181, 16'h0182, 16'h0183, 16'h0184, 16'h0185,
		16'h0186, 16'h0187, 16'h0188, 16'h0189, 16'h018A, 16'h018B, 16'h018C, 16'h018D,
		16'h018E, 16'h018F, 16'h0190, 16'h0194, 16'h01A1, 16'h01A2, 16'h01A3, 16'h01A4,
		16'h01AC, 16'h01AD, 16'h01AE, 16'h01AF, 16'h01C5, 16'h01C7, 16'h01C8, 16'h01CC,
		16'h01CD, 16'h01CF, 16'h01D0, 16'h01D4, 16'h01D6, 16'h01FC, 16'h01FE, 16'h0201,
		16'h0207};
	// field positions and reset values
	localparam int OPC_RUN_FWD = 0;
	localparam int OPC_RUN_REV = 1;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] SINGLE_WORD_LEN = 8'h01;
	// times in ns and derived cycle counts
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned STORE_COMMIT_NS = 400_000_000;
	localparam int unsigned APPLY_COMMIT_NS = 190_000_000;
	localparam int unsigned GR_FAST_NS = 1_300_000;
	localparam int unsigned GRW_FAST_NS = 3_000_000;
	localparam int unsigned GLB_SER_NS = 4_000_000;
	localparam int unsigned STORE_COMMIT_CYC = STORE_COMMIT_NS / CLK_PERIOD_NS;
	localparam int unsigned APPLY_COMMIT_CYC = APPLY_COMMIT_NS / CLK_PERIOD_NS;
	localparam int unsigned GR_FAST_CYC = GR_FAST_NS / CLK_PERIOD_NS;
	localparam int unsigned GRW_FAST_CYC = GRW_FAST_NS / CLK_PERIOD_NS;
	localparam int unsigned GLB_SER_CYC = GLB_SER_NS / CLK_PERIOD_NS;
	// serial path framing
	localparam int unsigned SER_DIV_DEF = 8;
	localparam logic [5:0] SER_OUT_BITS = 6'h20;
	localparam logic [5:0] SER_LAST_BIT = 6'h2F;

	typedef enum logic [2:0] {
		DNRA_IDLE = 3'b001,
		DNRA_SER = 3'b010,
		DNRA_WAIT = 3'b100
	} dnra_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic global_op;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [7:0] len;
	} dnra_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [15:0] rdata;
	} dnra_resp_t;

	function automatic logic dnra_is_run_op(input logic [15:0] a);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < RUN_OP_COUNT; i++) begin
			if (RUN_OP_TABLE[i] == a) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction
endpackage

//--- verification/dnra_drive_mem.sv
// Purpose: drive memory at the far end of the serial path
// Assumes: 32 bits out (register number, data) then 16 read bits, MSB first
// Notes: ser_in toggles every cycle whenever the model is not driving it
`timescale 1ns/1ps
module dnra_drive_mem (
	input wire logic clk,
	input wire logic ser_frame,
	input wire logic ser_dir,
	input wire logic ser_out,
	input wire logic ser_tick,
	output logic ser_in,
	output logic [15:0] last_addr,
	output logic [15:0] last_wdata
);
	logic [15:0] mem [logic [15:0]];
	logic [31:0] sh;
	logic [15:0] rd;
	int n;
	initial begin
		ser_in = 1'b0;
		n = 0;
	end
	always @(posedge clk) begin
		if (!ser_frame) begin
			n = 0;
		end else if (ser_tick) begin
			if (n < 32) begin
				sh = {sh[30:0], ser_out};
			end
			n = n + 1;
			if (n == 32) begin
				last_addr <= sh[31:16];
				last_wdata <= sh[15:0];
				if (ser_dir) begin
					mem[sh[31:16]] = sh[15:0];
				end
				// unwritten words read back as a fill pattern
				rd = mem.exists(sh[31:16]) ? mem[sh[31:16]] : 16'hC3A5;
			end
		end
		// each answer bit is held a whole bit period so the synchroniser sees it settled
		if (ser_frame && !ser_dir && n >= 32 && n < 48) begin
			ser_in <= rd[47 - n];
		end else begin
			ser_in <= ~ser_in;
		end
	end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench for the drive network register access block
// Assumes: shortened commit and global delays, serial divider 8
// Notes: outputs are read at clock edges, before that edge's updates land
`timescale 1ns/1ps
module testbench;
	import dnra_pkg::*;
	localparam int unsigned AP = 10;
	localparam int unsigned ST = 20;
	localparam int unsigned GR = 3;
	localparam int unsigned GRW = 5;
	localparam int unsigned GS = 7;
	localparam int unsigned DV = 8;
	localparam logic [15:0] MDL = 16'h0A5A; // arbitrary value
	localparam logic [15:0] OPC = ADDR_OPERATION_COMMAND;
	localparam logic [15:0] FRQ = ADDR_FREQUENCY_REFERENCE;
	localparam logic [15:0] NODE = ADDR_GLOBAL_WRITE_NODE_NUMBER;
	localparam logic WR = 1'b1;
	localparam logic RD = 1'b0;
	localparam logic GL = 1'b1;
	localparam logic DI = 1'b0;
	logic clk, rst_n, global_read_en, cable_loss_det_en, link_alive, commit_store, commit_apply;
	logic freq_scale_sel, ser_in, ser_frame, ser_dir, ser_out, ser_tick, req_ready, external_fault_code;
	logic cable_loss, run_inhibit, keypad_write_protect, commit_busy, commit_done, exp_resp, err;
	logic [4:0] drv_addr;
	logic [15:0] drv_rdata, op_command, freq_cmd, rdata, last_addr, last_wdata;
	logic [15:0] ra [4];
	logic [7:0] rl [4];
	dnra_req_t req;
	dnra_resp_t resp;
	int err_count, n_checks, lat;

	dnra_core #(.STORE_CYC(ST), .APPLY_CYC(AP), .GR_CYC(GR), .GRW_CYC(GRW), .GSER_CYC(GS), .SER_DIV(DV),
		.MODEL_NUMBER(MDL)) i_dut (.clk, .rst_n, .req, .resp, .req_ready, .global_read_en, .cable_loss_det_en,
		.link_alive, .commit_store, .commit_apply, .freq_scale_sel, .drv_addr, .drv_rdata, .ser_frame,
		.ser_dir, .ser_out, .ser_tick, .ser_in, .op_command, .freq_cmd, .external_fault_code, .cable_loss,
		.run_inhibit, .keypad_write_protect, .commit_busy, .commit_done);
	dnra_drive_mem i_mem (.clk, .ser_frame, .ser_dir, .ser_out, .ser_tick, .ser_in, .last_addr, .last_wdata);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic hang();
		err_count++;
		final_report();
	endtask

	task automatic clks(input int n);
		repeat (n) @(posedge clk);
	endtask

	// lat counts edges from take to answer; a global op expects no answer at all
	task automatic acc(input logic w, input logic g, input logic [15:0] a, input logic [15:0] d,
		input logic [7:0] n = 8'h01);
		int k;
		k = 0;
		@(posedge clk);
		req <= '{1'b1, w, g, a, d, n};
		do begin
			@(posedge clk);
			k++;
		end while (req_ready !== 1'b1 && k < 50);
		if (k == 50) hang();
		req.valid <= 1'b0;
		exp_resp <= !g;
		lat = 0;
		if (g) begin
			clks(20);
			return;
		end
		do begin
			@(posedge clk);
			lat++;
		end while (resp.valid !== 1'b1 && lat < 2000);
		if (lat == 2000) hang();
		exp_resp <= 1'b0;
		rdata = resp.rdata;
		err = resp.err;
	endtask

	task automatic sl(input int x);
		chk(16'(lat >= 2 + 47 * DV + x && lat <= 2 + 49 * DV + x), 16'h0001);
	endtask

	task automatic cmt(input logic st, input int unsigned cyc);
		int c;
		@(posedge clk);
		commit_store <= st;
		commit_apply <= !st;
		@(posedge clk);
		commit_store <= 1'b0;
		commit_apply <= 1'b0;
		c = 0;
		do begin
			@(posedge clk);
			c++;
			if (c == 2) begin
				chk(16'(commit_busy), 16'h0001);
				chk(16'({run_inhibit, keypad_write_protect}), 16'h0000);
			end
		end while (commit_done !== 1'b1 && c < 1000);
		if (c == 1000) hang();
		chk(16'(c), 16'(cyc + 1));
		chk(16'(commit_busy), 16'h0000);
	endtask

	// an answer with no request outstanding would be a transaction of the block's own
	always @(posedge clk) begin
		if (resp.valid === 1'b1) begin
			chk(16'(exp_resp), 16'h0001);
		end
	end

	initial begin
		err_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		req = '0;
		global_read_en = 1'b0;
		cable_loss_det_en = 1'b1;
		link_alive = 1'b0;
		commit_store = 1'b0;
		commit_apply = 1'b0;
		freq_scale_sel = 1'b0;
		drv_addr = 5'h00;
		exp_resp = 1'b0;
		ra = '{NODE, ADDR_DRIVE_MODEL_NUMBER, ADDR_GLOBAL_FREQUENCY_MULTIPLIER, 16'h0010};
		rl = '{8'h02, 8'h01, 8'h00, 8'h01};
		clks(3);
		rst_n <= 1'b1;
		clks(20);
		chk(16'({cable_loss, run_inhibit, keypad_write_protect, commit_busy}), 16'h0000);
		acc(WR, GL, OPC, 16'h0003);
		chk(16'(cable_loss), 16'h0000);
		chk(op_command, 16'h0000);
		acc(RD, DI, NODE, 16'h0000);
		chk(rdata, 16'h0000);
		clks(5);
		chk(16'(cable_loss), 16'h0001);
		acc(RD, DI, ADDR_GLOBAL_FREQUENCY_MULTIPLIER, 16'h0000);
		chk(rdata, 16'h0001);
		acc(RD, DI, ADDR_DRIVE_MODEL_NUMBER, 16'h0000);
		chk(rdata, MDL);
		link_alive <= 1'b1;
		clks(6);
		chk(16'(cable_loss), 16'h0000);
		$display("test reset and cable loss done");
		acc(WR, DI, OPC, 16'h0003);
		chk(16'(lat), 16'h0002);
		clks(2);
		chk(op_command, 16'h0003);
		chk(16'(external_fault_code), 16'h0001);
		acc(WR, DI, OPC, 16'h0001);
		clks(2);
		chk(16'(external_fault_code), 16'h0000);
		acc(WR, DI, FRQ, 16'h1770);
		acc(RD, DI, FRQ, 16'h0000);
		chk(rdata, 16'h1770);
		chk(16'(lat), 16'h0002);
		drv_addr <= 5'h02;
		clks(3);
		chk(drv_rdata, 16'h1770);
		chk(freq_cmd, 16'h1770);
		acc(WR, DI, ADDR_GLOBAL_FREQUENCY_MULTIPLIER, 16'h0003);
		freq_scale_sel <= 1'b1;
		clks(3);
		chk(freq_cmd, 16'h4650);
		$display("test fast registers done");
		for (int i = 0; i < 4; i++) begin
			acc(i == 1 || i == 2, DI, ra[i], 16'h0001, rl[i]);
			chk(16'(err), 16'h0001);
		end
		chk(freq_cmd, 16'h4650);
		$display("test refusals done");
		acc(WR, DI, 16'h0300, 16'hBEEF);
		sl(0);
		chk(last_addr, 16'h0300);
		chk(last_wdata, 16'hBEEF);
		chk(16'({run_inhibit, keypad_write_protect}), 16'h0003);
		acc(RD, DI, 16'h0300, 16'h0000);
		sl(0);
		chk(rdata, 16'hBEEF);
		cmt(1'b0, AP);
		acc(WR, DI, 16'h0180, 16'h1234);
		chk(16'({run_inhibit, keypad_write_protect}), 16'h0001);
		cmt(1'b1, ST);
		$display("test serial and commit done");
		global_read_en <= 1'b1;
		acc(RD, DI, FRQ, 16'h0000);
		chk(16'(lat), 16'(2 + GR));
		acc(RD, DI, 16'h0300, 16'h0000);
		sl(GS);
		global_read_en <= 1'b0;
		acc(WR, DI, NODE, 16'h0005);
		acc(RD, DI, FRQ, 16'h0000);
		chk(16'(lat), 16'(2 + GRW));
		acc(WR, DI, OPC, 16'h0000);
		chk(16'(err), 16'h0001);
		acc(WR, GL, FRQ, 16'h0BB8);
		chk(freq_cmd, 16'h2328);
		acc(WR, GL, OPC, 16'h0003);
		chk(16'(external_fault_code), 16'h0001);
		acc(WR, GL, OPC, 16'h0000);
		$display("test global exchange done");
		final_report();
	end
endmodule
